// ---- design/pfc_dead_time.sv ----
`timescale 1ns/1ps
module pfc_dead_time (
   input wire logic clk_in, // peripheral clock
   input wire logic rst_in, // sync reset, high
   input wire logic wave_in, // routed output
   input wire logic [pfc_pkg::DT_W-1:0] low_side_dead_time_in, // reload on rise
   input wire logic [pfc_pkg::DT_W-1:0] high_side_dead_time_in, // reload on fall
   output logic low_side_output_out, // non-inverted side
   output logic high_side_output_out // inverted side
);
   logic prev_reg;
   logic [pfc_pkg::DT_W-1:0] cnt_reg;
   logic [pfc_pkg::DT_W-1:0] cnt_next;
   logic rise;
   logic fall;
   logic idle;

   assign rise = wave_in && !prev_reg;
   assign fall = !wave_in && prev_reg;
   assign cnt_next = rise ? low_side_dead_time_in :
                     fall ? high_side_dead_time_in :
                     (cnt_reg != '0) ? cnt_reg - 1'b1 : cnt_reg;
   // sides driven from the next count so neither side is on while counting
   assign idle = (cnt_next == '0);

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         prev_reg <= 1'b0;
         cnt_reg <= '0;
         low_side_output_out <= 1'b0;
         high_side_output_out <= 1'b0;
      end else begin
         prev_reg <= wave_in;
         cnt_reg <= cnt_next;
         low_side_output_out <= wave_in && idle;
         high_side_output_out <= !wave_in && idle;
      end
   end

   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);

   never_both_a : assert property (!(low_side_output_out && high_side_output_out))
      else $error("both sides on together");
   dead_off_a : assert property ((cnt_reg != '0) |-> !low_side_output_out && !high_side_output_out)
      else $error("side on during dead time");
   rise_load_a : assert property (rise |=> cnt_reg == $past(low_side_dead_time_in))
      else $error("rise reload wrong");
   fall_load_a : assert property (fall |=> cnt_reg == $past(high_side_dead_time_in))
      else $error("fall reload wrong");
endmodule : pfc_dead_time

// ---- design/pfc_fault_filter.sv ----
`timescale 1ns/1ps
module pfc_fault_filter (
   input wire logic clk_in, // peripheral clock
   input wire logic rst_in, // sync reset, high
   input wire logic event_in, // raw fault event
   input wire logic [pfc_pkg::FLT_W-1:0] len_in, // fault_filter_length
   output logic event_out // qualified event
);
   logic [pfc_pkg::FLT_W-1:0] cnt_reg;
   logic [pfc_pkg::FLT_W-1:0] cnt_next;

   // a pulse shorter than the filter length never reaches the count
   assign cnt_next = !event_in ? '0 : (cnt_reg == len_in) ? cnt_reg : cnt_reg + 1'b1;
   assign event_out = (len_in == '0) ? event_in : (event_in && cnt_reg == len_in);

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         cnt_reg <= '0;
      end else begin
         cnt_reg <= cnt_next;
      end
   end
endmodule : pfc_fault_filter

// ---- design/pfc_pkg.sv ----
package pfc_pkg;
   localparam int WO_CNT = 8;
   localparam int CH_CNT = 4;
   localparam int CNT_W = 24;
   localparam logic [23:0] CNT_MAX = 24'hFFFFFF;
   localparam int FLT_W = 4;
   localparam int DT_W = 8;
   // byte offsets on the register bus
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_EVCTRL = 8'h04;
   localparam logic [7:0] OFS_DRVCTRL = 8'h08;
   localparam logic [7:0] OFS_DTCTRL = 8'h0C;
   localparam logic [7:0] OFS_PATT = 8'h10;
   localparam logic [7:0] OFS_PATTBUF = 8'h14;
   localparam logic [7:0] OFS_STATUS = 8'h18;
   localparam logic [7:0] OFS_CC0 = 8'h20;
   localparam logic [7:0] OFS_CC1 = 8'h24;
   localparam logic [7:0] OFS_CC2 = 8'h28;
   localparam logic [7:0] OFS_CC3 = 8'h2C;
   // control fields
   localparam int CTRL_MSYNC = 0;
   localparam int CTRL_LUPD = 1;
   localparam int CTRL_DBGF = 2;
   localparam int CTRL_RAMP_LSB = 3;
   localparam int CTRL_OUTPUT_ROUTING_LSB = 5;
   localparam int EV0_ACT_LSB = 0;
   localparam int EV1_ACT_LSB = 4;
   localparam int DRV_OVR_EN_LSB = 0;
   localparam int DRV_OVR_VAL_LSB = 8;
   localparam int DRV_FLT0_LSB = 16;
   localparam int DRV_FLT1_LSB = 20;
   localparam int DT_LS_LSB = 0;
   localparam int DT_HS_LSB = 8;
   localparam int DT_EN_LSB = 16;
   localparam int PATT_EN_LSB = 0;
   localparam int PATT_VAL_LSB = 8;
   localparam int ST_MC_LSB = 0;
   localparam int ST_ERR = 4;
   localparam int ST_DFS = 5;
   localparam int ST_UFS = 6;
   localparam int ST_NRF0 = 7;
   localparam int ST_NRF1 = 8;
   // encodings
   localparam logic [1:0] RAMP_SINGLE = 2'h0;
   localparam logic [1:0] RAMP_DUAL = 2'h1;
   localparam logic [1:0] RAMP_DUAL_ALT = 2'h2;
   localparam logic [1:0] RAMP_DUAL_SLOPE_BOTH_MODE = 2'h3;
   localparam logic [1:0] ACT_OFF = 2'h0;
   localparam logic [1:0] ACT_FAULT = 2'h1;
   localparam logic [1:0] ACT_STAMP = 2'h2;
   localparam logic [1:0] OUTPUT_ROUTING_MOD = 2'h0;
   localparam logic [1:0] OUTPUT_ROUTING_HALF = 2'h1;
   localparam logic [1:0] OUTPUT_ROUTING_CC0 = 2'h2;
   localparam logic [1:0] OUTPUT_ROUTING_CC0_CC1 = 2'h3;
   // reset values
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [23:0] DRV_RST = 24'h000000;
   localparam logic [19:0] DT_RST = 20'h00000;
   localparam logic [15:0] PATT_RST = 16'h0000;
endpackage : pfc_pkg

// ---- design/pfc_top.sv ----
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/1ps
// How it works
// - fault forces enabled outputs to override value
// - event fault only when action selects fault
// - nonzero filter delays fault, rejects glitches
// - debug entry with enable sets debug fault
// - locked update in dual ramp plus ramp index or direction change sets fault
// - capture event copies counter to channel
// - overflow writes counter maximum into channel
// - valid capture sets channel capture flag
// - capture while flag set: discard, flag error
// - slice x pairs outputs x and x+4
// - routing 0: channels repeat modulo count
// - routing 1: channels repeat modulo half
// - routing 2: all outputs from channel 0
// - routing 3: output 0 ch0, others ch1
// - four dead-time units, sides never together
// - 8-bit count down forces both sides off
// - rise loads low-side, fall high-side time
// - pattern buffered to update, direct write immediate
// - slave sync uses master counter
module pfc_top (
   input wire logic MCLK_IN, // 40 MHz clock
   input wire logic RST_IN, // sync reset, high
   input wire logic PSEL_IN, // apb select
   input wire logic PENABLE_IN, // apb enable
   input wire logic PWRITE_IN, // apb direction
   input wire logic [7:0] PADDR_IN, // apb byte address
   input wire logic [31:0] PWDATA_IN, // apb write data
   output logic [31:0] PRDATA_OUT, // apb read data
   output logic PREADY_OUT, // apb ready
   output logic PSLVERR_OUT, // apb error
   input wire logic [23:0] COUNT_IN, // own counter value
   input wire logic [23:0] MASTER_COUNT_IN, // master instance counter
   input wire logic UPDATE_IN, // update condition pulse
   input wire logic OVF_IN, // counter overflow pulse
   input wire logic RAMP_INDEX_IN, // current ramp index
   input wire logic DIR_IN, // counting direction
   input wire logic DEBUG_IN, // system in debug
   input wire logic COUNTER_EVENT_ZERO_IN, // counter event 0
   input wire logic COUNTER_EVENT_ONE_IN, // counter event 1
   input wire logic [3:0] CAPTURE_EV_IN, // per-channel capture events
   input wire logic [3:0] COMPARE_IN, // per-channel compare outputs
   output logic [7:0] WAVEFORM_OUTPUT_OUT, // final pin levels
   output logic FAULT_ACTIVE_OUT // any fault state held
);
   localparam int WN = pfc_pkg::WO_CNT;
   localparam int HN = pfc_pkg::WO_CNT / 2;

   function automatic logic [1:0] route_ch(input logic [1:0] code, input int idx);
      logic [1:0] ch;
      ch = 2'h0;
      unique case (code)
         pfc_pkg::OUTPUT_ROUTING_MOD: ch = 2'(idx % pfc_pkg::CH_CNT);
         pfc_pkg::OUTPUT_ROUTING_HALF: ch = 2'(idx % (pfc_pkg::CH_CNT / 2));
         pfc_pkg::OUTPUT_ROUTING_CC0: ch = 2'h0;
         pfc_pkg::OUTPUT_ROUTING_CC0_CC1: ch = (idx == 0) ? 2'h0 : 2'h1;
      endcase
      return ch;
   endfunction : route_ch

   logic [7:0] ctrl_reg;
   logic [7:0] evctrl_reg;
   logic [23:0] drv_reg;
   logic [19:0] dt_reg;
   logic [15:0] patt_reg;
   logic [15:0] patt_next;
   logic [15:0] pbuf_reg;
   logic pend_reg;
   logic [3:0] mc_reg;
   logic err_reg;
   logic dfs_reg;
   logic ufs_reg;
   logic [1:0] nrf_reg;
   logic [23:0] cc_reg [pfc_pkg::CH_CNT];
   logic ramp_prev_reg;
   logic dir_prev_reg;
   logic dbg_prev_reg;
   logic pready_reg;

   // bus decode
   wire acc = PSEL_IN && PENABLE_IN && pready_reg;
   wire wr = acc && PWRITE_IN;
   wire rd_start = PSEL_IN && PENABLE_IN && !pready_reg;
   wire hit_cc = (PADDR_IN[7:4] == pfc_pkg::OFS_CC0[7:4]) && (PADDR_IN[1:0] == 2'h0);
   wire [1:0] cc_idx = PADDR_IN[3:2];
   wire hit = hit_cc || PADDR_IN == pfc_pkg::OFS_CTRL || PADDR_IN == pfc_pkg::OFS_EVCTRL
      || PADDR_IN == pfc_pkg::OFS_DRVCTRL || PADDR_IN == pfc_pkg::OFS_DTCTRL
      || PADDR_IN == pfc_pkg::OFS_PATT || PADDR_IN == pfc_pkg::OFS_PATTBUF
      || PADDR_IN == pfc_pkg::OFS_STATUS;
   wire [8:0] status = {nrf_reg, ufs_reg, dfs_reg, err_reg, mc_reg};
   wire [31:0] rd_data =
      hit_cc ? {8'h00, cc_reg[cc_idx]} :
      PADDR_IN == pfc_pkg::OFS_CTRL ? {24'h000000, ctrl_reg} :
      PADDR_IN == pfc_pkg::OFS_EVCTRL ? {24'h000000, evctrl_reg} :
      PADDR_IN == pfc_pkg::OFS_DRVCTRL ? {8'h00, drv_reg} :
      PADDR_IN == pfc_pkg::OFS_DTCTRL ? {12'h000, dt_reg} :
      PADDR_IN == pfc_pkg::OFS_PATT ? {16'h0000, patt_reg} :
      PADDR_IN == pfc_pkg::OFS_PATTBUF ? {16'h0000, pbuf_reg} :
      PADDR_IN == pfc_pkg::OFS_STATUS ? {23'h0, status} : 32'h00000000;
   wire wr_status = wr && PADDR_IN == pfc_pkg::OFS_STATUS;
   wire [8:0] clr = wr_status ? PWDATA_IN[8:0] : 9'h000;

   // control fields
   wire [1:0] ramp_mode = ctrl_reg[pfc_pkg::CTRL_RAMP_LSB +: 2];
   wire [1:0] output_routing = ctrl_reg[pfc_pkg::CTRL_OUTPUT_ROUTING_LSB +: 2];
   wire [1:0] act0 = evctrl_reg[pfc_pkg::EV0_ACT_LSB +: 2];
   wire [1:0] act1 = evctrl_reg[pfc_pkg::EV1_ACT_LSB +: 2];
   wire [7:0] ovr_en = drv_reg[pfc_pkg::DRV_OVR_EN_LSB +: 8];
   wire [7:0] ovr_val = drv_reg[pfc_pkg::DRV_OVR_VAL_LSB +: 8];
   wire [7:0] patt_en = patt_reg[pfc_pkg::PATT_EN_LSB +: 8];
   wire [7:0] patt_val = patt_reg[pfc_pkg::PATT_VAL_LSB +: 8];

   // non-recoverable faults
   wire filt0;
   wire filt1;
   pfc_fault_filter u_flt0 (
      .clk_in(MCLK_IN),
      .rst_in(RST_IN),
      .event_in(COUNTER_EVENT_ZERO_IN),
      .len_in(drv_reg[pfc_pkg::DRV_FLT0_LSB +: pfc_pkg::FLT_W]),
      .event_out(filt0)
   );
   pfc_fault_filter u_flt1 (
      .clk_in(MCLK_IN),
      .rst_in(RST_IN),
      .event_in(COUNTER_EVENT_ONE_IN),
      .len_in(drv_reg[pfc_pkg::DRV_FLT1_LSB +: pfc_pkg::FLT_W]),
      .event_out(filt1)
   );
   wire [1:0] nrf_set = {filt1 && act1 == pfc_pkg::ACT_FAULT,
                         filt0 && act0 == pfc_pkg::ACT_FAULT};
   wire dual = ramp_mode != pfc_pkg::RAMP_SINGLE;
   wire ufs_set = ctrl_reg[pfc_pkg::CTRL_LUPD] && dual
      && (RAMP_INDEX_IN != ramp_prev_reg || DIR_IN != dir_prev_reg);
   wire dfs_set = ctrl_reg[pfc_pkg::CTRL_DBGF] && DEBUG_IN && !dbg_prev_reg;
   wire fault_any = |nrf_reg || dfs_reg || ufs_reg;

   // time-stamp capture; the counter must stay below max so max marks overflow
   wire stamp_en = act0 == pfc_pkg::ACT_STAMP || act1 == pfc_pkg::ACT_STAMP;
   wire [23:0] count_src = ctrl_reg[pfc_pkg::CTRL_MSYNC] ? MASTER_COUNT_IN : COUNT_IN;
   wire [23:0] stamp = OVF_IN ? pfc_pkg::CNT_MAX : count_src;
   wire [3:0] cap_trig = stamp_en ? (CAPTURE_EV_IN | {4{OVF_IN}}) : 4'h0;
   wire [3:0] mc_busy = mc_reg & ~clr[pfc_pkg::ST_MC_LSB +: 4];
   wire [3:0] cap_ok = cap_trig & ~mc_busy;
   wire err_set = |(cap_trig & mc_busy);

   // output matrix and dead time
   logic [WN-1:0] routed;
   logic [WN-1:0] dti_out;
   for (genvar g = 0; g < WN; g++) begin : g_route
      assign routed[g] = COMPARE_IN[route_ch(output_routing, g)];
   end
   for (genvar s = 0; s < HN; s++) begin : g_slice
      wire ls;
      wire hs;
      wire dt_on = dt_reg[pfc_pkg::DT_EN_LSB + s];
      pfc_dead_time u_dt (
         .clk_in(MCLK_IN),
         .rst_in(RST_IN),
         .wave_in(routed[s]),
         .low_side_dead_time_in(dt_reg[pfc_pkg::DT_LS_LSB +: pfc_pkg::DT_W]),
         .high_side_dead_time_in(dt_reg[pfc_pkg::DT_HS_LSB +: pfc_pkg::DT_W]),
         .low_side_output_out(ls),
         .high_side_output_out(hs)
      );
      assign dti_out[s] = dt_on ? ls : routed[s];
      assign dti_out[s + HN] = dt_on ? hs : routed[s + HN];
   end
   // fault override has the last word over pattern and dead time
   wire [WN-1:0] patt_out = (patt_en & patt_val) | (~patt_en & dti_out);
   wire [WN-1:0] wave_next = fault_any ? ((ovr_en & ovr_val) | (~ovr_en & patt_out))
                                       : patt_out;

   // pattern: direct write wins over a buffered copy in the same cycle
   wire wr_patt = wr && PADDR_IN == pfc_pkg::OFS_PATT;
   wire wr_pbuf = wr && PADDR_IN == pfc_pkg::OFS_PATTBUF;
   wire load_buf = UPDATE_IN && pend_reg;
   assign patt_next = wr_patt ? PWDATA_IN[15:0] : load_buf ? pbuf_reg : patt_reg;

   always_ff @(posedge MCLK_IN) begin
      if (RST_IN) begin
         ctrl_reg <= pfc_pkg::CTRL_RST;
         evctrl_reg <= 8'h00;
         drv_reg <= pfc_pkg::DRV_RST;
         dt_reg <= pfc_pkg::DT_RST;
         pbuf_reg <= pfc_pkg::PATT_RST;
      end else if (wr) begin
         if (PADDR_IN == pfc_pkg::OFS_CTRL) ctrl_reg <= PWDATA_IN[7:0];
         if (PADDR_IN == pfc_pkg::OFS_EVCTRL) evctrl_reg <= PWDATA_IN[7:0];
         if (PADDR_IN == pfc_pkg::OFS_DRVCTRL) drv_reg <= PWDATA_IN[23:0];
         if (PADDR_IN == pfc_pkg::OFS_DTCTRL) dt_reg <= PWDATA_IN[19:0];
         if (wr_pbuf) pbuf_reg <= PWDATA_IN[15:0];
      end
   end

   always_ff @(posedge MCLK_IN) begin
      if (RST_IN) begin
         patt_reg <= pfc_pkg::PATT_RST;
         pend_reg <= 1'b0;
      end else begin
         patt_reg <= patt_next;
         pend_reg <= wr_pbuf || (pend_reg && !UPDATE_IN);
      end
   end

   // sticky flags: a hardware set wins over a software clear
   always_ff @(posedge MCLK_IN) begin
      if (RST_IN) begin
         mc_reg <= 4'h0;
         err_reg <= 1'b0;
         dfs_reg <= 1'b0;
         ufs_reg <= 1'b0;
         nrf_reg <= 2'h0;
      end else begin
         mc_reg <= cap_ok | mc_busy;
         err_reg <= err_set || (err_reg && !clr[pfc_pkg::ST_ERR]);
         dfs_reg <= dfs_set || (dfs_reg && !clr[pfc_pkg::ST_DFS]);
         ufs_reg <= ufs_set || (ufs_reg && !clr[pfc_pkg::ST_UFS]);
         nrf_reg <= nrf_set | (nrf_reg & ~clr[pfc_pkg::ST_NRF0 +: 2]);
      end
   end

   always_ff @(posedge MCLK_IN) begin
      if (RST_IN) begin
         for (int i = 0; i < pfc_pkg::CH_CNT; i++) cc_reg[i] <= 24'h000000;
      end else begin
         for (int i = 0; i < pfc_pkg::CH_CNT; i++) begin
            if (cap_ok[i]) cc_reg[i] <= stamp;
         end
      end
   end

   always_ff @(posedge MCLK_IN) begin
      if (RST_IN) begin
         ramp_prev_reg <= 1'b0;
         dir_prev_reg <= 1'b0;
         dbg_prev_reg <= 1'b0;
         WAVEFORM_OUTPUT_OUT <= 8'h00;
         FAULT_ACTIVE_OUT <= 1'b0;
         pready_reg <= 1'b0;
         PRDATA_OUT <= 32'h00000000;
         PSLVERR_OUT <= 1'b0;
      end else begin
         ramp_prev_reg <= RAMP_INDEX_IN;
         dir_prev_reg <= DIR_IN;
         dbg_prev_reg <= DEBUG_IN;
         WAVEFORM_OUTPUT_OUT <= wave_next;
         FAULT_ACTIVE_OUT <= fault_any;
         pready_reg <= rd_start;
         if (rd_start) begin
            PRDATA_OUT <= PWRITE_IN ? 32'h00000000 : rd_data;
            PSLVERR_OUT <= !hit;
         end else begin
            PSLVERR_OUT <= 1'b0;
         end
      end
   end
   assign PREADY_OUT = pready_reg;

   default clocking @(posedge MCLK_IN); endclocking
   default disable iff (RST_IN);

   sequence cap_busy2_s;
      cap_trig[2] && mc_busy[2];
   endsequence
   sequence debug_entry_s;
      ctrl_reg[pfc_pkg::CTRL_DBGF] && !DEBUG_IN ##1 ctrl_reg[pfc_pkg::CTRL_DBGF] && DEBUG_IN;
   endsequence

   fault_override_a : assert property (fault_any && ovr_en[0] |=>
      WAVEFORM_OUTPUT_OUT[0] == $past(ovr_val[0]))
      else $error("override level not applied");
   fault_gate_a : assert property ($rose(nrf_reg[0]) |->
      $past(act0 == pfc_pkg::ACT_FAULT && filt0))
      else $error("fault without fault action");
   filter_delay_a : assert property ($rose(nrf_reg[0]) &&
      $past(drv_reg[pfc_pkg::DRV_FLT0_LSB +: pfc_pkg::FLT_W]) == 4'h3 |->
      $past(COUNTER_EVENT_ZERO_IN, 4) && $past(COUNTER_EVENT_ZERO_IN, 3)
      && $past(COUNTER_EVENT_ZERO_IN, 2))
      else $error("filter passed short event");
   debug_fault_a : assert property (debug_entry_s |=> dfs_reg)
      else $error("debug fault not raised");
   update_fault_a : assert property (ufs_set |=> ufs_reg ##1 FAULT_ACTIVE_OUT)
      else $error("update fault not held");
   stamp_copy_a : assert property (cap_ok[2] && !OVF_IN |=> cc_reg[2] == $past(count_src))
      else $error("stamp not copied");
   overflow_max_a : assert property (cap_ok[1] && OVF_IN |=> cc_reg[1] == pfc_pkg::CNT_MAX)
      else $error("overflow max not written");
   capture_flag_a : assert property (cap_ok[2] |=> mc_reg[2])
      else $error("capture flag not set");
   capture_error_a : assert property (cap_busy2_s |=> err_reg && $stable(cc_reg[2]))
      else $error("busy capture not discarded");
   pattern_load_a : assert property (load_buf && !wr_patt |=> patt_reg == $past(pbuf_reg))
      else $error("buffered pattern not loaded");
   slave_sync_a : assert property (ctrl_reg[pfc_pkg::CTRL_MSYNC] && cap_ok[1] && !OVF_IN |=>
      cc_reg[1] == $past(MASTER_COUNT_IN))
      else $error("slave not on master counter");
endmodule : pfc_top

// ---- dv/pfc_counter_model.sv ----
`timescale 1ns/1ps
module pfc_counter_model #(
   parameter logic [23:0] TOP = 24'h00003F
) (
   input wire logic clk_in, // peripheral clock
   input wire logic rst_in, // sync reset, high
   input wire logic run_in, // counter running
   output logic [23:0] count_out, // own counter
   output logic [23:0] master_count_out, // master counter
   output logic ovf_out, // wrap pulse
   output logic update_out, // update condition pulse
   output logic ramp_out // ramp index, flips at each wrap
);
   logic wrap;
   // top kept below maximum so an overflow stamp differs from any count
   assign wrap = run_in && (count_out == TOP);
   assign master_count_out = count_out + 24'h000100;
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         count_out <= 24'h000000;
         ovf_out <= 1'b0;
         update_out <= 1'b0;
         ramp_out <= 1'b0;
      end else begin
         ovf_out <= wrap;
         update_out <= wrap;
         if (wrap) begin
            count_out <= 24'h000000;
            ramp_out <= ~ramp_out;
         end else if (run_in) begin
            count_out <= count_out + 24'h000001;
         end
      end
   end
endmodule : pfc_counter_model

// ---- dv/pfc_fault_capture_waveform_ext_tb.sv ----
`timescale 1ns/1ps
module pfc_fault_capture_waveform_ext_tb;
   logic clk, rst, psel, penable, pwrite, pready, pslverr, upd, ovf, ramp, dbg, ev0, ev1;
   logic run, look, flt, dir;
   logic [7:0] paddr, wave;
   logic [31:0] prdata, pwdata, seed;
   logic [23:0] count, mcount, old;
   logic [3:0] cap, cmp;
   logic [33:0] rd_q[$];
   logic [8:0] wv_q[$];
   logic [33:0] bus_exp;
   int mismatches, n_checks;
   pfc_top pfc_top_inst(.MCLK_IN(clk), .RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(penable),
      .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
      .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .COUNT_IN(count), .MASTER_COUNT_IN(mcount),
      .UPDATE_IN(upd), .OVF_IN(ovf), .RAMP_INDEX_IN(ramp), .DIR_IN(dir), .DEBUG_IN(dbg),
      .COUNTER_EVENT_ZERO_IN(ev0), .COUNTER_EVENT_ONE_IN(ev1), .CAPTURE_EV_IN(cap),
      .COMPARE_IN(cmp), .WAVEFORM_OUTPUT_OUT(wave), .FAULT_ACTIVE_OUT(flt));
   pfc_counter_model pfc_counter_model_inst(.clk_in(clk), .rst_in(rst), .run_in(run),
      .count_out(count), .master_count_out(mcount), .ovf_out(ovf), .update_out(upd),
      .ramp_out(ramp));
   always #12.5 clk = ~clk;
   task automatic check(input string nm, input logic [32:0] seen, input logic [32:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   // results are matched oldest first, so expectations must be queued in issue order
   always @(negedge clk) begin
      if (pready === 1'b1 && psel === 1'b1 && penable === 1'b1) begin
         if (rd_q.size() == 0) begin
            check("unexpected bus answer", 33'h0, 33'h1);
         end else begin
            bus_exp = rd_q.pop_front();
            if (bus_exp[33]) check("read data", {pslverr, prdata}, bus_exp[32:0]);
            else check("write error", {pslverr, 32'h0}, {bus_exp[32], 32'h0});
         end
      end
      if (look === 1'b1) check("outputs", {24'h0, flt, wave}, {24'h0, wv_q.pop_front()});
   end
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(negedge clk);
      while (pready !== 1'b1) @(negedge clk);
      @(posedge clk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic err);
      rd_q.push_back({1'b0, err, 32'h0});
      apb(1'b1, a, d);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [32:0] e);
      rd_q.push_back({1'b1, e});
      apb(1'b0, a, 32'h0);
   endtask : rd
   task automatic see(input logic [8:0] e);
      wv_q.push_back(e);
      @(posedge clk);
      look <= 1'b1;
      @(posedge clk);
      look <= 1'b0;
   endtask : see
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick
   task automatic pulse(input logic one, input int n);
      @(posedge clk);
      if (one) ev1 <= 1'b1;
      else ev0 <= 1'b1;
      tick(n);
      ev0 <= 1'b0;
      ev1 <= 1'b0;
   endtask : pulse
   task automatic grab(input logic [3:0] ch);
      @(posedge clk);
      cap <= ch;
      @(posedge clk);
      cap <= 4'h0;
      tick(2);
   endtask : grab
   task automatic run_to_update;
      int k;
      k = 0;
      @(posedge clk);
      run <= 1'b1;
      while (upd !== 1'b1 && k < 200) begin
         @(negedge clk);
         k++;
      end
      if (k >= 200) mismatches++;
      @(posedge clk);
      run <= 1'b0;
      tick(3);
   endtask : run_to_update
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs
   function automatic logic [7:0] route(input logic [1:0] c, input logic [3:0] m);
      logic [7:0] r;
      for (int i = 0; i < 8; i++) begin
         case (c)
            2'h0: r[i] = m[i % 4];
            2'h1: r[i] = m[i % 2];
            2'h2: r[i] = m[0];
            default: r[i] = (i == 0) ? m[0] : m[1];
         endcase
      end
      return r;
   endfunction : route
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : report_and_stop
   initial begin
      #500000;
      mismatches++;
      report_and_stop();
   end
   initial begin
      {clk, psel, penable, pwrite, dbg, ev0, ev1, run, look, dir} = 10'h0;
      {paddr, pwdata, cap, cmp} = 48'h0;
      bus_exp = 34'h0;
      rst = 1'b1;
      seed = 32'h00000036;
      tick(20);
      rst <= 1'b0;
      rd(pfc_pkg::OFS_CTRL, 33'h0);
      rd(pfc_pkg::OFS_DTCTRL, 33'h0);
      rd(pfc_pkg::OFS_STATUS, 33'h0);
      rd(8'h3C, 33'h1_0000_0000);
      wr(8'h3C, 32'hFFFF_FFFF, 1'b1);
      $display("test registers done");
      for (int c = 0; c < 4; c++) begin
         wr(pfc_pkg::OFS_CTRL, 32'(c) << pfc_pkg::CTRL_OUTPUT_ROUTING_LSB, 1'b0);
         for (int k = 0; k < 3; k++) begin
            seed = xs(seed);
            @(posedge clk);
            cmp <= seed[3:0];
            tick(2);
            see({1'b0, route(c[1:0], seed[3:0])});
         end
      end
      $display("test routing done");
      wr(pfc_pkg::OFS_CTRL, 32'h0, 1'b0);
      cmp <= 4'h0;
      wr(pfc_pkg::OFS_PATT, 32'h0000_A5F0, 1'b0);
      see(9'h0A0);
      wr(pfc_pkg::OFS_PATTBUF, 32'h0000_5A0F, 1'b0);
      see(9'h0A0);
      run_to_update();
      see(9'h00A);
      wr(pfc_pkg::OFS_PATTBUF, 32'h0, 1'b0);
      wr(pfc_pkg::OFS_PATT, 32'h0, 1'b0);
      $display("test pattern done");
      cmp <= 4'hF;
      wr(pfc_pkg::OFS_DRVCTRL, 32'h0003_050F, 1'b0);
      pulse(1'b0, 6);
      see(9'h0FF);
      wr(pfc_pkg::OFS_EVCTRL, 32'h0000_0011, 1'b0);
      pulse(1'b0, 3);
      see(9'h0FF);
      pulse(1'b0, 6);
      tick(2);
      see(9'h1F5);
      rd(pfc_pkg::OFS_STATUS, 33'h080);
      wr(pfc_pkg::OFS_STATUS, 32'h080, 1'b0);
      pulse(1'b1, 1);
      tick(2);
      rd(pfc_pkg::OFS_STATUS, 33'h100);
      wr(pfc_pkg::OFS_STATUS, 32'h100, 1'b0);
      tick(2);
      see(9'h0FF);
      $display("test fault done");
      wr(pfc_pkg::OFS_CTRL, 32'h04, 1'b0);
      // enable must already stand in the cycle before debug entry
      tick(1);
      dbg <= 1'b1;
      tick(3);
      rd(pfc_pkg::OFS_STATUS, 33'h020);
      wr(pfc_pkg::OFS_STATUS, 32'h020, 1'b0);
      dbg <= 1'b0;
      wr(pfc_pkg::OFS_CTRL, 32'h0A, 1'b0);
      run_to_update();
      rd(pfc_pkg::OFS_STATUS, 33'h040);
      wr(pfc_pkg::OFS_STATUS, 32'h040, 1'b0);
      wr(pfc_pkg::OFS_CTRL, 32'h1A, 1'b0);
      dir <= 1'b1;
      tick(2);
      rd(pfc_pkg::OFS_STATUS, 33'h040);
      wr(pfc_pkg::OFS_STATUS, 32'h040, 1'b0);
      $display("test debug and update faults done");
      wr(pfc_pkg::OFS_CTRL, 32'h0, 1'b0);
      wr(pfc_pkg::OFS_EVCTRL, 32'h22, 1'b0);
      grab(4'h4);
      old = count;
      rd(pfc_pkg::OFS_CC2, {9'h0, old});
      rd(pfc_pkg::OFS_STATUS, 33'h04);
      run <= 1'b1;
      tick(5);
      run <= 1'b0;
      grab(4'h4);
      rd(pfc_pkg::OFS_CC2, {9'h0, old});
      rd(pfc_pkg::OFS_STATUS, 33'h14);
      wr(pfc_pkg::OFS_STATUS, 32'h14, 1'b0);
      wr(pfc_pkg::OFS_CTRL, 32'h01, 1'b0);
      grab(4'h2);
      rd(pfc_pkg::OFS_CC1, {9'h0, mcount});
      wr(pfc_pkg::OFS_STATUS, 32'h02, 1'b0);
      run_to_update();
      rd(pfc_pkg::OFS_CC0, {9'h0, pfc_pkg::CNT_MAX});
      rd(pfc_pkg::OFS_CC3, {9'h0, pfc_pkg::CNT_MAX});
      rd(pfc_pkg::OFS_STATUS, 33'h0F);
      $display("test capture done");
      wr(pfc_pkg::OFS_CTRL, 32'h0, 1'b0);
      wr(pfc_pkg::OFS_EVCTRL, 32'h0, 1'b0);
      cmp <= 4'h0;
      wr(pfc_pkg::OFS_DTCTRL, 32'h0001_060A, 1'b0);
      tick(20);
      see(9'h010);
      cmp <= 4'h1;
      tick(1);
      see(9'h000);
      tick(15);
      see(9'h001);
      cmp <= 4'h0;
      tick(1);
      see(9'h000);
      tick(12);
      see(9'h010);
      $display("test dead time done");
      tick(4);
      report_and_stop();
   end
endmodule : pfc_fault_capture_waveform_ext_tb
